// *** design/jtag_tap_instruction_logic.sv ***
`timescale 1ns/1ps
module jtag_tap_instruction_logic #(
  parameter int          BSR_LENGTH = tap_pkg::BSR_LENGTH_DEFAULT,
  parameter logic [3:0]  ID_VERSION = 4'h0,          // arbitrary value
  parameter logic [15:0] ID_PART    = 16'h1234,      // arbitrary value
  parameter logic [10:0] ID_MAKER   = 11'h055,       // arbitrary value
  parameter logic [31:0] USER_CODE  = tap_pkg::USER_CODE_DEFAULT
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // test pins
  input  wire logic                  tck,
  input  wire logic                  tms,
  input  wire logic                  tdi,
  output logic                       tdo,
  output logic                       tdo_oe,
  // device pins seen by the boundary cells
  input  wire logic [BSR_LENGTH-1:0] pin_in,
  input  wire logic [BSR_LENGTH-1:0] core_out,
  output logic      [BSR_LENGTH-1:0] pin_out,
  output logic                       pins_from_bsr,
  output logic                       pins_high_z,
  output logic                       keep_weak_pull,
  // user chain port
  input  wire logic                  user_tdo_a,
  input  wire logic                  user_tdo_b,
  output logic                       user_sel_a,
  output logic                       user_sel_b,
  output logic                       user_tdi,
  output logic                       user_tck_rise,
  output logic                       user_capture,
  output logic                       user_shift,
  output logic                       user_update,
  output logic [3:0]                 user_state,
  // programming instruction port
  input  wire logic                  prog_tdo,
  output logic                       prog_active,
  output logic [9:0]                 prog_ir
);
  // ****************************************
  // pin sampling
  // ****************************************
  logic tms_s, tdi_s, tck_rise, tck_fall;

  scan_link_sampler scan_link_sampler_inst (
    .clk      (clk),
    .resetn   (resetn),
    .tck      (tck),
    .tms      (tms),
    .tdi      (tdi),
    .tms_s    (tms_s),
    .tdi_s    (tdi_s),
    .tck_rise (tck_rise),
    .tck_fall (tck_fall)
  );

  // ****************************************
  // decode helpers
  // ****************************************
  // unknown codes fall back to bypass unless the programming space claims them
  function automatic logic is_known(input logic [9:0] op);
    case (op)
      tap_pkg::OP_SAMPLE_PRELOAD, tap_pkg::OP_EXT_TEST, tap_pkg::OP_BYPASS,
      tap_pkg::OP_USER_CODE, tap_pkg::OP_IDENT_CODE, tap_pkg::OP_HIGH_Z,
      tap_pkg::OP_CLAMP, tap_pkg::OP_USER_CHAIN_A, tap_pkg::OP_USER_CHAIN_B:
        is_known = 1'b1;
      default: is_known = 1'b0;
    endcase
  endfunction : is_known

  // programming space: top bit set and not all-ones bypass
  function automatic logic is_prog(input logic [9:0] op);
    is_prog = op[9] & (op != tap_pkg::OP_BYPASS);
  endfunction : is_prog

  function automatic logic [31:0] ident_value();
    logic [31:0] v;
    v = '0;
    v[31:tap_pkg::ID_VERSION_LSB]                      = ID_VERSION;
    v[tap_pkg::ID_VERSION_LSB-1:tap_pkg::ID_PART_LSB]  = ID_PART;
    v[tap_pkg::ID_PART_LSB-1:tap_pkg::ID_MAKER_LSB]    = ID_MAKER;
    v[0]                                               = 1'b1;
    ident_value = v;
  endfunction : ident_value

  // ****************************************
  // state
  // ****************************************
  tap_pkg::tap_state_e state, next_state;
  logic [9:0]            ir_shift, next_ir_shift;
  logic [9:0]            ir, next_ir;
  logic [31:0]           code_shift, next_code_shift;
  logic                  bypass, next_bypass;
  logic [BSR_LENGTH-1:0] bsr_shift, next_bsr_shift;
  logic [BSR_LENGTH-1:0] bsr_hold, next_bsr_hold;
  logic                  tdo_r, next_tdo;
  logic                  tdo_oe_r, next_tdo_oe;

  // per-instruction routing
  logic sel_bsr, sel_code, sel_ident, sel_a, sel_b, sel_prog;
  always_comb begin
    sel_ident = (ir == tap_pkg::OP_IDENT_CODE);
    sel_code  = (ir == tap_pkg::OP_USER_CODE) || sel_ident;
    sel_bsr   = (ir == tap_pkg::OP_SAMPLE_PRELOAD) || (ir == tap_pkg::OP_EXT_TEST);
    sel_a     = (ir == tap_pkg::OP_USER_CHAIN_A);
    sel_b     = (ir == tap_pkg::OP_USER_CHAIN_B);
    sel_prog  = is_prog(ir);
  end

  // sixteen-state controller, stepped on each test clock rise
  always_comb begin
    next_state = state;
    if (tck_rise) begin
      case (state)
        tap_pkg::ST_RESET:      next_state = tms_s ? tap_pkg::ST_RESET : tap_pkg::ST_IDLE;
        tap_pkg::ST_IDLE:       next_state = tms_s ? tap_pkg::ST_DR_SELECT : tap_pkg::ST_IDLE;
        tap_pkg::ST_DR_SELECT:  next_state = tms_s ? tap_pkg::ST_IR_SELECT : tap_pkg::ST_DR_CAPTURE;
        tap_pkg::ST_DR_CAPTURE: next_state = tms_s ? tap_pkg::ST_DR_EXIT1 : tap_pkg::ST_DR_SHIFT;
        tap_pkg::ST_DR_SHIFT:   next_state = tms_s ? tap_pkg::ST_DR_EXIT1 : tap_pkg::ST_DR_SHIFT;
        tap_pkg::ST_DR_EXIT1:   next_state = tms_s ? tap_pkg::ST_DR_UPDATE : tap_pkg::ST_DR_PAUSE;
        tap_pkg::ST_DR_PAUSE:   next_state = tms_s ? tap_pkg::ST_DR_EXIT2 : tap_pkg::ST_DR_PAUSE;
        tap_pkg::ST_DR_EXIT2:   next_state = tms_s ? tap_pkg::ST_DR_UPDATE : tap_pkg::ST_DR_SHIFT;
        tap_pkg::ST_DR_UPDATE:  next_state = tms_s ? tap_pkg::ST_DR_SELECT : tap_pkg::ST_IDLE;
        tap_pkg::ST_IR_SELECT:  next_state = tms_s ? tap_pkg::ST_RESET : tap_pkg::ST_IR_CAPTURE;
        tap_pkg::ST_IR_CAPTURE: next_state = tms_s ? tap_pkg::ST_IR_EXIT1 : tap_pkg::ST_IR_SHIFT;
        tap_pkg::ST_IR_SHIFT:   next_state = tms_s ? tap_pkg::ST_IR_EXIT1 : tap_pkg::ST_IR_SHIFT;
        tap_pkg::ST_IR_EXIT1:   next_state = tms_s ? tap_pkg::ST_IR_UPDATE : tap_pkg::ST_IR_PAUSE;
        tap_pkg::ST_IR_PAUSE:   next_state = tms_s ? tap_pkg::ST_IR_EXIT2 : tap_pkg::ST_IR_PAUSE;
        tap_pkg::ST_IR_EXIT2:   next_state = tms_s ? tap_pkg::ST_IR_UPDATE : tap_pkg::ST_IR_SHIFT;
        tap_pkg::ST_IR_UPDATE:  next_state = tms_s ? tap_pkg::ST_DR_SELECT : tap_pkg::ST_IDLE;
        default:                next_state = tap_pkg::ST_RESET;
      endcase
    end
  end

  // instruction path: capture, shift, update on the rise
  always_comb begin
    next_ir_shift = ir_shift;
    next_ir       = ir;
    if (tck_rise) begin
      case (state)
        tap_pkg::ST_RESET:      next_ir = tap_pkg::IR_RESET_VALUE;
        tap_pkg::ST_IR_CAPTURE: next_ir_shift = tap_pkg::IR_CAPTURE_VALUE;
        tap_pkg::ST_IR_SHIFT:   next_ir_shift = {tdi_s, ir_shift[9:1]};
        tap_pkg::ST_IR_UPDATE:  next_ir = (is_known(ir_shift) || is_prog(ir_shift)) ?
                                          ir_shift : tap_pkg::OP_BYPASS;
        default:                next_ir_shift = ir_shift;
      endcase
    end
  end

  // data path: code, bypass and boundary registers
  always_comb begin
    next_code_shift = code_shift;
    next_bypass     = bypass;
    next_bsr_shift  = bsr_shift;
    next_bsr_hold   = bsr_hold;
    if (tck_rise) begin
      case (state)
        tap_pkg::ST_DR_CAPTURE: begin
          next_code_shift = sel_ident ? ident_value() : USER_CODE;
          next_bypass     = 1'b0;
          if (sel_bsr)
            next_bsr_shift = pin_in;
        end
        tap_pkg::ST_DR_SHIFT: begin
          next_code_shift = {tdi_s, code_shift[31:1]};
          next_bypass     = tdi_s;
          if (sel_bsr)
            next_bsr_shift = {tdi_s, bsr_shift[BSR_LENGTH-1:1]};
        end
        tap_pkg::ST_DR_UPDATE: begin
          if (sel_bsr)
            next_bsr_hold = bsr_shift;
        end
        default: next_bypass = bypass;
      endcase
    end
  end

  // serial output changes on the falling test clock edge
  always_comb begin
    next_tdo    = tdo_r;
    next_tdo_oe = tdo_oe_r;
    if (tck_fall) begin
      next_tdo_oe = (state == tap_pkg::ST_IR_SHIFT) || (state == tap_pkg::ST_DR_SHIFT);
      if (state == tap_pkg::ST_IR_SHIFT)
        next_tdo = ir_shift[0];
      else if (sel_code)
        next_tdo = code_shift[0];
      else if (sel_bsr)
        next_tdo = bsr_shift[0];
      else if (sel_a)
        next_tdo = user_tdo_a;
      else if (sel_b)
        next_tdo = user_tdo_b;
      else if (sel_prog)
        next_tdo = prog_tdo;
      else
        next_tdo = bypass;
    end
  end

  // user and pin-facing outputs, all registered
  logic [BSR_LENGTH-1:0] next_pin_out;
  logic                  next_from_bsr, next_high_z;
  logic                  next_user_tck_rise, next_user_capture, next_user_shift, next_user_update;
  always_comb begin
    next_from_bsr = (ir == tap_pkg::OP_EXT_TEST) || (ir == tap_pkg::OP_CLAMP);
    next_high_z   = (ir == tap_pkg::OP_HIGH_Z);
    next_pin_out  = next_from_bsr ? bsr_hold : core_out;
    next_user_tck_rise = tck_rise & (sel_a | sel_b);
    next_user_capture  = (sel_a | sel_b) & (state == tap_pkg::ST_DR_CAPTURE);
    next_user_shift    = (sel_a | sel_b) & (state == tap_pkg::ST_DR_SHIFT);
    next_user_update   = (sel_a | sel_b) & (state == tap_pkg::ST_DR_UPDATE);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state         <= tap_pkg::ST_RESET;
      ir_shift      <= '0;
      ir            <= tap_pkg::IR_RESET_VALUE;
      code_shift    <= '0;
      bypass        <= 1'b0;
      bsr_shift     <= '0;
      bsr_hold      <= '0;
      tdo_r         <= 1'b0;
      tdo_oe_r      <= 1'b0;
      pin_out       <= '0;
      pins_from_bsr <= 1'b0;
      pins_high_z   <= 1'b0;
      user_sel_a    <= 1'b0;
      user_sel_b    <= 1'b0;
      user_tdi      <= 1'b0;
      user_tck_rise <= 1'b0;
      user_capture  <= 1'b0;
      user_shift    <= 1'b0;
      user_update   <= 1'b0;
      user_state    <= 4'h0;
      prog_active   <= 1'b0;
      prog_ir       <= '0;
      keep_weak_pull <= 1'b1;
    end else begin
      state         <= next_state;
      ir_shift      <= next_ir_shift;
      ir            <= next_ir;
      code_shift    <= next_code_shift;
      bypass        <= next_bypass;
      bsr_shift     <= next_bsr_shift;
      bsr_hold      <= next_bsr_hold;
      tdo_r         <= next_tdo;
      tdo_oe_r      <= next_tdo_oe;
      pin_out       <= next_pin_out;
      pins_from_bsr <= next_from_bsr;
      pins_high_z   <= next_high_z;
      user_sel_a    <= sel_a;
      user_sel_b    <= sel_b;
      user_tdi      <= tdi_s;
      user_tck_rise <= next_user_tck_rise;
      user_capture  <= next_user_capture;
      user_shift    <= next_user_shift;
      user_update   <= next_user_update;
      user_state    <= state;
      prog_active   <= sel_prog;
      prog_ir       <= ir;
      keep_weak_pull <= 1'b1;
    end
  end

  // test modes never turn keepers off, so the pull flag is a held one
  assign tdo            = tdo_r;
  assign tdo_oe         = tdo_oe_r;

  // ****************************************
  // checks
  // ****************************************
  sequence s_ir_update_rise;
    state == tap_pkg::ST_IR_UPDATE && tck_rise;
  endsequence

  a_reset_on_tms: assert property (@(posedge clk) disable iff (!resetn)
    (state == tap_pkg::ST_IR_SELECT && tck_rise && tms_s) |=> state == tap_pkg::ST_RESET)
    else $error("controller did not reach reset");
  a_unknown_bypass: assert property (@(posedge clk) disable iff (!resetn)
    (s_ir_update_rise and !is_known(ir_shift) && !is_prog(ir_shift)) |=> ir == tap_pkg::OP_BYPASS)
    else $error("unknown code not mapped to bypass");
  a_ir_full_width: assert property (@(posedge clk) disable iff (!resetn)
    s_ir_update_rise |=> ir == $past(ir_shift) || ir == tap_pkg::OP_BYPASS)
    else $error("instruction not taken at full width");
  a_user_code_ones: assert property (@(posedge clk) disable iff (!resetn)
    (state == tap_pkg::ST_DR_CAPTURE && tck_rise && ir == tap_pkg::OP_USER_CODE) |=> code_shift == USER_CODE)
    else $error("user code capture wrong");
  a_ident_lsb: assert property (@(posedge clk) disable iff (!resetn)
    (state == tap_pkg::ST_DR_CAPTURE && tck_rise && sel_ident) |=> code_shift[0] && code_shift[31:28] == ID_VERSION)
    else $error("identity capture wrong");
  a_highz_pins: assert property (@(posedge clk) disable iff (!resetn)
    ir == tap_pkg::OP_HIGH_Z |=> pins_high_z && !pins_from_bsr)
    else $error("pins not released in high-z mode");
  a_clamp_pins: assert property (@(posedge clk) disable iff (!resetn)
    ir == tap_pkg::OP_CLAMP |=> pins_from_bsr && pin_out == $past(bsr_hold))
    else $error("clamp pins not held from cells");
  a_bsr_capture: assert property (@(posedge clk) disable iff (!resetn)
    (state == tap_pkg::ST_DR_CAPTURE && tck_rise && sel_bsr) |=> bsr_shift == $past(pin_in))
    else $error("boundary capture missed");
  a_user_chain_sel: assert property (@(posedge clk) disable iff (!resetn)
    !(user_sel_a && user_sel_b))
    else $error("both user chains selected");
  a_keep_pulls: assert property (@(posedge clk) disable iff (!resetn) keep_weak_pull)
    else $error("weak pulls dropped");
  // serial output follows the selected register, one clock after the fall
  a_code_serial_out: assert property (@(posedge clk) disable iff (!resetn)
    (tck_fall && state == tap_pkg::ST_DR_SHIFT && sel_code) |=> tdo == $past(code_shift[0]))
    else $error("code register bit not driven out");
  a_extest_drive: assert property (@(posedge clk) disable iff (!resetn)
    ir == tap_pkg::OP_EXT_TEST |=> pins_from_bsr && pin_out == $past(bsr_hold))
    else $error("extest pins not driven from cells");
  a_user_a_out: assert property (@(posedge clk) disable iff (!resetn)
    (tck_fall && state == tap_pkg::ST_DR_SHIFT && sel_a) |=> tdo == $past(user_tdo_a))
    else $error("chain a data not passed out");
  a_user_b_out: assert property (@(posedge clk) disable iff (!resetn)
    (tck_fall && state == tap_pkg::ST_DR_SHIFT && sel_b) |=> tdo == $past(user_tdo_b))
    else $error("chain b data not passed out");
endmodule : jtag_tap_instruction_logic

// *** design/tap_pkg.sv ***
package tap_pkg;
  // ****************************************
  // instruction register
  // ****************************************
  localparam int          IR_WIDTH           = 10;
  localparam logic [9:0]  OP_SAMPLE_PRELOAD  = 10'h005;
  localparam logic [9:0]  OP_EXT_TEST        = 10'h00f;
  localparam logic [9:0]  OP_BYPASS          = 10'h3ff;
  localparam logic [9:0]  OP_USER_CODE       = 10'h007;
  localparam logic [9:0]  OP_IDENT_CODE      = 10'h006;
  localparam logic [9:0]  OP_HIGH_Z          = 10'h00b;
  localparam logic [9:0]  OP_CLAMP           = 10'h00a;
  localparam logic [9:0]  OP_USER_CHAIN_A    = 10'h00c;
  localparam logic [9:0]  OP_USER_CHAIN_B    = 10'h00e;
  localparam logic [9:0]  IR_CAPTURE_VALUE   = 10'h001;
  localparam logic [9:0]  IR_RESET_VALUE     = 10'h006;
  // ****************************************
  // data registers
  // ****************************************
  localparam int          CODE_WIDTH         = 32;
  localparam logic [31:0] USER_CODE_DEFAULT  = 32'hffff_ffff;
  localparam int          ID_VERSION_LSB     = 28;
  localparam int          ID_PART_LSB        = 12;
  localparam int          ID_MAKER_LSB       = 1;
  localparam int          BSR_LENGTH_DEFAULT = 240;
  // ****************************************
  // controller states, gray in listed order from reset all the way through ir update
  // ****************************************
  typedef enum logic [3:0] {
    ST_RESET      = 4'h0,
    ST_IDLE       = 4'h1,
    ST_DR_SELECT  = 4'h3,
    ST_DR_CAPTURE = 4'h2,
    ST_DR_SHIFT   = 4'h6,
    ST_DR_EXIT1   = 4'h7,
    ST_DR_PAUSE   = 4'h5,
    ST_DR_EXIT2   = 4'h4,
    ST_DR_UPDATE  = 4'hc,
    ST_IR_SELECT  = 4'hd,
    ST_IR_CAPTURE = 4'hf,
    ST_IR_SHIFT   = 4'he,
    ST_IR_EXIT1   = 4'ha,
    ST_IR_PAUSE   = 4'hb,
    ST_IR_EXIT2   = 4'h9,
    ST_IR_UPDATE  = 4'h8
  } tap_state_e;
endpackage : tap_pkg

// *** design/scan_link_sampler.sv ***
`timescale 1ns/1ps
// two-stage sampler of the test pins, with edge pulses for the test clock
module scan_link_sampler (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // raw test pins
  input  wire logic tck,
  input  wire logic tms,
  input  wire logic tdi,
  // sampled values
  output logic      tms_s,
  output logic      tdi_s,
  output logic      tck_rise,
  output logic      tck_fall
);
  logic [2:0] meta;
  logic [2:0] sync;
  logic       tck_last;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta     <= 3'h0;
      sync     <= 3'h0;
      tck_last <= 1'b0;
    end else begin
      meta     <= {tck, tms, tdi};
      sync     <= meta;
      tck_last <= sync[2];
    end
  end

  // edges found on the settled copy only
  assign tms_s    = sync[1];
  assign tdi_s    = sync[0];
  assign tck_rise = sync[2] & ~tck_last;
  assign tck_fall = ~sync[2] & tck_last;
endmodule : scan_link_sampler

// *** tb/host_model.sv ***
`timescale 1ns/1ps
// ****************************************
// test controller model
// ****************************************
module host_model (
  // test pins toward the device
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  // serial data back
  input  wire logic tdo
);
  // link clock parks low between frames, it never runs free
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one test clock of 64 ns, tdo taken just before the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #32;
    q   = tdo;
    tck = 1'b1;
    #32;
    tck = 1'b0;
  endtask : step
  // five high tms clocks reach reset from anywhere, then idle
  task automatic reset_tap;
    logic q;
    repeat (5) step(1'b1, tdi, q);
    step(1'b0, tdi, q);
  endtask : reset_tap
  // no scan traffic until supplies and configuration have settled
  task automatic power_up;
    #2000;
    reset_tap();
  endtask : power_up
  // ir or dr frame from idle back to idle, lsb first; any code goes this way
  task automatic shift(input logic ir, input int n, input logic [255:0] din, output logic [255:0] dout);
    logic q;
    dout = '0;
    step(1'b1, tdi, q);
    if (ir) step(1'b1, tdi, q);
    step(1'b0, tdi, q);
    step(1'b0, tdi, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    // tdi released: show the inverse, not a stale copy
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask : shift
endmodule : host_model

// *** tb/jtag_tap_instruction_logic_tb_top.sv ***
`timescale 1ns/1ps
// ****************************************
// bench top
// ****************************************
module jtag_tap_instruction_logic_tb_top;
  localparam int            BSR   = 240;
  localparam logic [3:0]    VER   = 4'h3;      // arbitrary value
  localparam logic [15:0]   PART  = 16'h5a5a;  // arbitrary value
  localparam logic [10:0]   MAKER = 11'h2c3;   // arbitrary value
  localparam logic [255:0]  PAT_A = {16'h0, {8{30'h2a5f_0c31}}};
  localparam logic [255:0]  PAT_B = {16'h0, {6{40'h93_c6e1_7a5d}}};
  localparam logic [255:0]  PAT_C = {16'h0, {10{24'h5c_a39f}}};
  localparam logic [255:0]  PAT_D = {16'h0, {15{16'h6b1e}}};
  logic            clk, resetn, tck, tms, tdi, tdo, pins_from_bsr, pins_high_z, keep_weak_pull;
  logic            tdo_oe, oe_last, user_tdi, user_capture, user_shift, user_update;
  logic [7:0]      ubits;
  logic            user_tdo_a, user_tdo_b, user_sel_a, user_sel_b, user_tck_rise, prog_tdo, prog_active;
  logic [BSR-1:0]  pin_in, core_out, pin_out;
  logic [3:0]      user_state;
  logic [9:0]      prog_ir;
  logic [255:0]    q;
  int              err_total, checked, rises, r0, frames, ucap, uupd, c0, u0;
  // device under test
  jtag_tap_instruction_logic #(.BSR_LENGTH(BSR), .ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER))
    jtag_tap_instruction_logic_inst (.clk(clk), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .pin_in(pin_in), .core_out(core_out), .pin_out(pin_out), .pins_from_bsr(pins_from_bsr),
    .pins_high_z(pins_high_z), .keep_weak_pull(keep_weak_pull), .user_tdo_a(user_tdo_a),
    .user_tdo_b(user_tdo_b), .user_sel_a(user_sel_a), .user_sel_b(user_sel_b), .user_tdi(user_tdi),
    .user_tck_rise(user_tck_rise), .user_capture(user_capture), .user_shift(user_shift),
    .user_update(user_update), .user_state(user_state),
    .prog_tdo(prog_tdo), .prog_active(prog_active), .prog_ir(prog_ir));
  host_model host_model_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  // 200 MHz clock; frame, user clock and user strobe counts
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    oe_last <= tdo_oe;
    if (tdo_oe === 1'b1 && oe_last === 1'b0) frames <= frames + 1;
    if (user_tck_rise === 1'b1) begin
      rises <= rises + 1;
      ucap  <= ucap + int'(user_capture === 1'b1);
      uupd  <= uupd + int'(user_update === 1'b1);
      if (user_shift === 1'b1) ubits <= {user_tdi, ubits[7:1]};
    end
  end
  task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // frames end with a short settle, outputs are registered
  task automatic dr(input int n, input logic [255:0] din);
    host_model_inst.shift(1'b0, n, din, q);
    repeat (8) @(posedge clk);
    #1;
  endtask : dr
  task automatic load_ir(input logic [9:0] code);
    host_model_inst.shift(1'b1, 10, {246'h0, code}, q);
    check("ir capture", q, 256'h1);
    repeat (8) @(posedge clk);
    #1;
  endtask : load_ir
  task automatic t_ident;
    dr(32, 256'h0);
    check("ident code", q, {224'h0, VER, PART, MAKER, 1'b1});
    check("ident low bit", q[0], 1'b1);
  endtask : t_ident
  task automatic t_code;
    load_ir(tap_pkg::OP_USER_CODE);
    dr(32, PAT_A);
    check("user code", q, 256'hffff_ffff);
  endtask : t_code
  // bypass family plus an unknown code differing only above bit 7
  task automatic t_bypass;
    logic [9:0] codes [4] = '{tap_pkg::OP_BYPASS, tap_pkg::OP_HIGH_Z, tap_pkg::OP_CLAMP, 10'h10b};
    int f0;
    f0 = frames;
    for (int i = 0; i < 4; i++) begin
      load_ir(codes[i]);
      dr(8, 256'hb4);
      check("bypass data", q, 256'h68);
      check("high z", pins_high_z, i == 1);
      check("pins from cells", pins_from_bsr, i == 2);
      check("weak pulls", keep_weak_pull, 1'b1);
    end
    check("shift frames", frames - f0, 8);
    check("oe idle", tdo_oe, 1'b0);
  endtask : t_bypass
  task automatic t_cells;
    @(posedge clk) #1 pin_in = PAT_A[BSR-1:0];
    load_ir(tap_pkg::OP_SAMPLE_PRELOAD);
    dr(BSR, PAT_B);
    check("sampled pins", q, PAT_A);
    check("core passes", pin_out, PAT_C);
    load_ir(tap_pkg::OP_EXT_TEST);
    check("preload driven", pin_out, PAT_B);
    @(posedge clk) #1 pin_in = PAT_D[BSR-1:0];
    dr(BSR, PAT_A);
    check("extest capture", q, PAT_D);
    check("extest drive", {pins_from_bsr, pin_out}, {1'b1, PAT_A[BSR-1:0]});
    check("weak pulls", keep_weak_pull, 1'b1);
    load_ir(tap_pkg::OP_CLAMP);
    check("clamp hold", {pins_from_bsr, pin_out}, {1'b1, PAT_A[BSR-1:0]});
  endtask : t_cells
  // the two chains return opposite constants so a swap shows
  task automatic t_user;
    @(posedge clk) #1 user_tdo_a = 1'b1;
    load_ir(tap_pkg::OP_USER_CHAIN_A);
    r0 = rises;
    c0 = ucap;
    u0 = uupd;
    dr(8, 256'h3c);
    check("chain a data", q, 256'hff);
    check("chain a select", {user_sel_a, user_sel_b}, 2'b10);
    check("user clock pulses", rises - r0, 13);
    check("user capture", ucap - c0, 1);
    check("user update", uupd - u0, 1);
    check("user tdi", ubits, 8'h3c);
    check("user state", user_state, tap_pkg::ST_IDLE);
    load_ir(tap_pkg::OP_USER_CHAIN_B);
    dr(8, 256'h3c);
    check("chain b data", q, 256'h0);
    check("chain b select", {user_sel_a, user_sel_b}, 2'b01);
  endtask : t_user
  task automatic t_prog;
    @(posedge clk) #1 prog_tdo = 1'b1;
    load_ir(10'h2a5);
    check("prog decode", {prog_active, prog_ir}, {1'b1, 10'h2a5});
    dr(8, 256'h0);
    check("prog data", q, 256'hff);
    @(posedge clk) #1 prog_tdo = 1'b0;
  endtask : t_prog
  // tms reset and a pin reset in mid-run both restore identity
  task automatic t_reset;
    load_ir(tap_pkg::OP_USER_CODE);
    host_model_inst.reset_tap();
    t_ident();
    load_ir(tap_pkg::OP_USER_CHAIN_A);
    @(posedge clk) #1 resetn = 1'b0;
    repeat (2) @(posedge clk);
    check("reset state", {user_sel_a, user_state}, {1'b0, tap_pkg::ST_RESET});
    @(posedge clk) #1 resetn = 1'b1;
    host_model_inst.reset_tap();
    t_ident();
  endtask : t_reset
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  // bounded run
  initial begin
    for (int n = 0; n < 100000; n++) @(posedge clk);
    err_total++;
    $display("mismatch run length expected end seen hang");
    stop_test();
  end
  initial begin
    {clk, resetn, user_tdo_a, user_tdo_b, prog_tdo, err_total, checked, rises, frames, ucap, uupd} = '0;
    {oe_last, ubits} = '0;
    pin_in   = '0;
    core_out = PAT_C[BSR-1:0];
    repeat (16) @(posedge clk);
    #1 resetn = 1'b1;
    host_model_inst.power_up();
    t_ident();
    $display("ident test done");
    t_code();
    $display("user code test done");
    t_bypass();
    $display("bypass test done");
    t_cells();
    $display("boundary test done");
    t_user();
    $display("user chain test done");
    t_prog();
    $display("programming test done");
    t_reset();
    $display("reset test done");
    stop_test();
  end
endmodule : jtag_tap_instruction_logic_tb_top
